// ### sim/tb_top.sv
// self-checking bench of the counter access and link interrupt block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import cali_pkg::*;
  // apb and counter store drive, all from the bench
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic cnt_ack = 1'b0;
  logic [23:0] cnt_rdata = '0;
  cali_ovf_t ovf_in = '0;
  logic [NLINK-1:0] cell_delineation_loss = '0;
  // design outputs
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cali_cnt_req_t cnt_req;
  logic cnt_req_valid;
  logic irq_n;
  // bench state
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] htop = 8'h00; // expected top holding
  logic [15:0] hlow = 16'h0000; // expected low holding
  logic [15:0] sel;
  logic [3:0] lk;
  logic [3:0] ct_tab [9] = '{CT_IN_ALL, CT_IN_IDLE, CT_IN_UNAS, CT_IN_HEC, CT_TX_ALL,
    CT_TX_IDLE, CT_RX_ALL, CT_RX_IDLE, CT_RX_HEC};
  logic [AW-1:0] rst_idx [7] = '{IDX_CNT_TOP, IDX_CNT_LOW, IDX_CNT_SEL, IDX_MMASK,
    IDX_TC_EN, IDX_LSTAT0, IDX_MSTAT};

  cali_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_req(cnt_req), .cnt_req_valid(cnt_req_valid), .cnt_ack(cnt_ack),
    .cnt_rdata(cnt_rdata), .ovf_in(ovf_in), .cell_delineation_loss(cell_delineation_loss),
    .irq_n(irq_n));

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // hang guard, well above the expected run length
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one apb transfer; waits for pready, only the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [AW-1:0] idx, input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= AW'(idx << 2);
    pwdata <= {16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // read a register and compare the full word, upper half must be zero
  task automatic rchk(input logic [AW-1:0] idx, input logic [15:0] ex, input string nm);
    apb(1'b0, idx, 16'h0000);
    `CHK(nm, {16'h0000, ex}, rd)
    `CHK("pslverr", 1'b0, er)
  endtask

  // command a transfer, watch busy and done, answer after a random stall
  task automatic xfer(input logic dir, input logic [23:0] v, input cali_cnt_req_t ex);
    apb(1'b1, IDX_CMD, {13'h0000, dir, CMD_XFER});
    while (cnt_req_valid !== 1'b1)
      @(posedge sys_clk);
    `CHK("cnt_req", ex, cnt_req)
    rchk(IDX_CMD, 16'h0000, "done while busy");
    // a second command while busy must be ignored
    apb(1'b1, IDX_CMD, {13'h0000, ~dir, CMD_XFER});
    `CHK("cnt_req busy", ex, cnt_req)
    tick($urandom_range(3, 0));
    cnt_rdata <= v;
    cnt_ack <= 1'b1;
    @(posedge sys_clk);
    cnt_ack <= 1'b0;
    tick(2);
    `CHK("cnt_req_valid", 1'b0, cnt_req_valid)
    rchk(IDX_CMD, 16'h0080, "done");
  endtask

  // select a counter, move it one way, then check both holding registers
  task automatic cnt_access(input logic dir, input logic [3:0] ct, input logic [3:0] l);
    logic [23:0] v;
    v = 24'($urandom);
    sel = {7'h00, ct, 1'b0, l};
    apb(1'b1, IDX_CNT_SEL, sel);
    rchk(IDX_CNT_SEL, sel, "select");
    if (dir)
    begin
      {htop, hlow} = v;
      apb(1'b1, IDX_CNT_TOP, {8'h00, htop});
      apb(1'b1, IDX_CNT_LOW, hlow);
    end
    xfer(dir, v, cali_cnt_req_t'{dir, ct, l, {htop, hlow}});
    // a fetch refills the holding pair, a load leaves it as staged
    {htop, hlow} = v;
    rchk(IDX_CNT_TOP, {8'h00, htop}, "top holding");
    rchk(IDX_CNT_LOW, hlow, "low holding");
  endtask

  // main sequence
  initial
  begin
    void'($urandom(87));
    tick(16);
    resetn <= 1'b1;
    @(posedge sys_clk);
    `CHK("irq_n reset", 1'b1, irq_n)
    foreach (rst_idx[i]) rchk(rst_idx[i], RST16, "reset value");
    rchk(IDX_CMD, 16'h0080, "done at reset");
    apb(1'b1, IDX_CNT_SEL, 16'hFFFF);
    rchk(IDX_CNT_SEL, 16'h01FF, "select read zero");
    apb(1'b1, IDX_CNT_TOP, 16'hFFFF);
    rchk(IDX_CNT_TOP, 16'h00FF, "top read zero");
    apb(1'b0, 16'h0470, 16'h0000);
    `CHK("unmapped pslverr", 1'b1, er)
    apb(1'b1, IDX_MSTAT, 16'hFFFF);
    `CHK("mstat write pslverr", 1'b1, er)
    // a command code other than transfer starts nothing
    apb(1'b1, IDX_CMD, 16'h0002);
    `CHK("cmd code ignored", 1'b0, cnt_req_valid)
    // every counter type, both directions, random link
    foreach (ct_tab[i])
    begin
      lk = 4'($urandom_range(15, 0));
      cnt_access(1'b1, ct_tab[i], lk);
      cnt_access(1'b0, ct_tab[i], lk);
    end
    // delineation loss start and end on one link
    lk = 4'($urandom_range(15, 0));
    apb(1'b1, IDX_LEN0 + AW'(lk), 16'h0202);
    apb(1'b1, IDX_MMASK, 16'h0001 << lk);
    cell_delineation_loss[lk] <= 1'b1;
    tick(6);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0002, "loss start");
    rchk(IDX_MSTAT, 16'h0001 << lk, "master status");
    `CHK("irq_n loss", 1'b0, irq_n)
    apb(1'b1, IDX_MMASK, 16'h0000);
    tick(2);
    `CHK("irq_n masked", 1'b1, irq_n)
    apb(1'b1, IDX_LSTAT0 + AW'(lk), 16'h0000);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0000, "loss cleared");
    cell_delineation_loss[lk] <= 1'b0;
    tick(6);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0200, "loss end");
    apb(1'b1, IDX_LSTAT0 + AW'(lk), 16'h0000);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0000, "end cleared");
    // two counters overflow on one link; bit 0 falls after both are accessed
    apb(1'b1, IDX_LEN0 + AW'(lk), 16'h0001);
    apb(1'b1, IDX_TC_EN, 16'h0001 << lk);
    apb(1'b1, IDX_MMASK, 16'h0001 << lk);
    ovf_in <= cali_ovf_t'{1'b1, CT_RX_HEC, lk};
    @(posedge sys_clk);
    ovf_in <= cali_ovf_t'{1'b1, CT_TX_ALL, lk};
    @(posedge sys_clk);
    ovf_in <= '0;
    tick(3);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0001, "overflow");
    `CHK("irq_n overflow", 1'b0, irq_n)
    apb(1'b1, IDX_TC_EN, 16'h0000);
    tick(2);
    `CHK("irq_n tc off", 1'b1, irq_n)
    apb(1'b1, IDX_TC_EN, 16'h0001 << lk);
    apb(1'b1, IDX_LSTAT0 + AW'(lk), 16'h0000);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0001, "overflow read only");
    cnt_access(1'b0, CT_RX_HEC, lk);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0001, "one flag left");
    cnt_access(1'b1, CT_TX_ALL, lk);
    rchk(IDX_LSTAT0 + AW'(lk), 16'h0000, "flags gone");
    `CHK("irq_n idle", 1'b1, irq_n)
    end_of_test();
  end
endmodule // tb_top

// ### src/cali_pkg.sv
// package with register map, field layout and carrier types of the counter access block
package cali_pkg;
  localparam int unsigned NLINK = 16; // links served
  localparam int unsigned AW = 16; // apb address width
  // register indices; byte address is four times the index
  localparam logic [AW-1:0] IDX_CNT_TOP = 16'h0430; // counter_top_byte_holding
  localparam logic [AW-1:0] IDX_CNT_LOW = 16'h0431; // counter_low_bytes_holding
  localparam logic [AW-1:0] IDX_CNT_SEL = 16'h0432; // counter_select
  localparam logic [AW-1:0] IDX_MMASK = 16'h0433; // link_irq_master_mask
  localparam logic [AW-1:0] IDX_TC_EN = 16'h0434; // tc_overflow_irq_enable
  localparam logic [AW-1:0] IDX_LSTAT0 = 16'h0435; // link_irq_status, link 0
  localparam logic [AW-1:0] IDX_LEN0 = 16'h0445; // per-link status enable, link 0
  localparam logic [AW-1:0] IDX_MSTAT = 16'h0455; // master status, read only
  localparam logic [AW-1:0] IDX_CMD = 16'h0460; // transfer command
  localparam logic [15:0] RST16 = 16'h0000; // reset value of all registers except the command register, whose done bit resets to 1
  // field positions
  localparam int unsigned SEL_TYPE_LSB = 5; // counter type 8:5
  localparam int unsigned SEL_LINK_LSB = 0; // link number 3:0
  localparam logic [15:0] SEL_RW_MASK = 16'h01FF; // bits 15:9 read zero
  localparam logic [15:0] TOP_RW_MASK = 16'h00FF; // bits 15:8 read zero
  localparam logic [15:0] LSTAT_RD_MASK = 16'h0FFF; // bits 15:12 read zero
  localparam int unsigned LS_OVF = 0; // counter overflow, read only
  localparam int unsigned LS_LCD = 1; // cell_delineation_loss start
  localparam int unsigned LS_LCD_END = 9; // cell_delineation_loss end
  localparam int unsigned CMD_DIR = 2; // 1: holding to counter
  localparam int unsigned CMD_DONE = 7; // transfer done
  localparam logic [1:0] CMD_XFER = 2'h1; // start counter transfer
  // counter type codes
  localparam logic [3:0] CT_IN_ALL = 4'hB;
  localparam logic [3:0] CT_IN_IDLE = 4'hA;
  localparam logic [3:0] CT_IN_UNAS = 4'h9;
  localparam logic [3:0] CT_IN_HEC = 4'h8;
  localparam logic [3:0] CT_TX_ALL = 4'h7;
  localparam logic [3:0] CT_TX_IDLE = 4'h6;
  localparam logic [3:0] CT_RX_ALL = 4'h3;
  localparam logic [3:0] CT_RX_IDLE = 4'h2;
  localparam logic [3:0] CT_RX_HEC = 4'h1;
  // request toward the counter store
  typedef struct packed {
    logic wr; // 1: load counter from data
    logic [3:0] ctype; // counter type
    logic [3:0] link; // link number
    logic [23:0] data; // value to load
  } cali_cnt_req_t;
  // overflow event from the counter store
  typedef struct packed {
    logic valid;
    logic [3:0] ctype;
    logic [3:0] link;
  } cali_ovf_t;
  // transfer state
  typedef enum logic [0:0] {XF_IDLE, XF_BUSY} cali_xfer_t;
endpackage

// ### src/cali_top.sv
// counter access holding registers, link interrupt status and apb slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module cali_top
  import cali_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter store port, same clock
  output cali_cnt_req_t cnt_req,
  output logic cnt_req_valid,
  input wire logic cnt_ack,
  input wire logic [23:0] cnt_rdata,
  input wire cali_ovf_t ovf_in,
  // per-link delineation loss level, from the receive clock side
  input wire logic [NLINK-1:0] cell_delineation_loss,
  // interrupt pin, active low
  output logic irq_n
);

  // register index of an apb byte address, or all ones if misaligned
  function automatic logic [AW-1:0] reg_index(input logic [AW-1:0] a);
    reg_index = (a[1:0] == 2'h0) ? {2'h0, a[AW-1:2]} : '1;
  endfunction

  // per-link request: enabled status bits, overflow also gated by tc enable
  function automatic logic link_req(input logic [15:0] st, input logic [15:0] en,
                                    input logic tc);
    logic [15:0] g;
    g = st & en & LSTAT_RD_MASK;
    g[LS_OVF] = g[LS_OVF] & tc;
    link_req = |g;
  endfunction

  // register state
  logic [15:0] top_q; // counter_top_byte_holding
  logic [15:0] low_q; // counter_low_bytes_holding
  logic [15:0] sel_q; // counter_select
  logic [15:0] mmask_q; // link_irq_master_mask
  logic [15:0] tc_en_q; // tc_overflow_irq_enable
  logic [15:0] lstat_q [NLINK]; // link_irq_status, bits 15:1 part
  logic [15:0] len_q [NLINK]; // per-link status enable
  logic [15:0] ovf_flag_q [NLINK]; // one flag per counter type code
  logic [NLINK-1:0] lcd_s1_q; // synchroniser first stage
  logic [NLINK-1:0] lcd_s2_q; // synchroniser second stage
  logic [NLINK-1:0] lcd_s3_q; // previous synced level for edges
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  cali_cnt_req_t cnt_req_q;
  logic cnt_req_valid_q;
  cali_xfer_t xf_q;
  logic done_q; // transfer finished
  logic irq_n_q;

  // bus decode
  logic [AW-1:0] idx; // index of current address
  logic setup; // setup phase
  logic wr_acc; // write taking effect this edge
  logic rd_hit; // address is mapped
  logic [31:0] rd_d; // read mux
  logic [NLINK-1:0] mstat; // master status
  logic [NLINK-1:0] lcd_rise;
  logic [NLINK-1:0] lcd_fall;
  logic start; // command write starting a transfer
  logic [3:0] idx_link; // link of a per-link register
  logic [NLINK-1:0] lcd_flag_v; // loss flag of each link
  logic [NLINK-1:0] lcd_end_v; // loss end flag of each link
  logic [NLINK-1:0] len_hi_v; // link has an enable above the overflow bit

  assign idx = reg_index(paddr);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite && !pslverr_q;
  assign idx_link = idx[3:0] - IDX_LSTAT0[3:0];
  assign start = wr_acc && idx == IDX_CMD && pwdata[1:0] == CMD_XFER;
  assign lcd_rise = lcd_s2_q & ~lcd_s3_q;
  assign lcd_fall = ~lcd_s2_q & lcd_s3_q;

  // master status, unlatched so an enable change acts at once
  always_comb
  begin
    for (int l = 0; l < NLINK; l++)
    begin
      mstat[l] = link_req({lstat_q[l][15:1], |ovf_flag_q[l]}, len_q[l], tc_en_q[l]);
    end
  end

  // per-link views of the status words, so the checks cover every link, not one
  always_comb
  begin
    for (int l = 0; l < NLINK; l++)
    begin
      lcd_flag_v[l] = lstat_q[l][LS_LCD];
      lcd_end_v[l] = lstat_q[l][LS_LCD_END];
      len_hi_v[l] = |len_q[l][15:1];
    end
  end

  // read mux; unused upper bits read zero
  always_comb
  begin
    rd_d = '0;
    rd_hit = 1'b1;
    if (idx == IDX_CNT_TOP)
      rd_d[15:0] = top_q & TOP_RW_MASK;
    else if (idx == IDX_CNT_LOW)
      rd_d[15:0] = low_q;
    else if (idx == IDX_CNT_SEL)
      rd_d[15:0] = sel_q & SEL_RW_MASK;
    else if (idx == IDX_MMASK)
      rd_d[15:0] = mmask_q;
    else if (idx == IDX_TC_EN)
      rd_d[15:0] = tc_en_q;
    else if (idx >= IDX_LSTAT0 && idx < IDX_LEN0)
    begin
      rd_d[15:0] = lstat_q[idx_link] & LSTAT_RD_MASK;
      rd_d[LS_OVF] = |ovf_flag_q[idx_link];
    end
    else if (idx >= IDX_LEN0 && idx < IDX_MSTAT)
      rd_d[15:0] = len_q[idx_link] & LSTAT_RD_MASK;
    else if (idx == IDX_MSTAT)
      rd_d[15:0] = mstat;
    else if (idx == IDX_CMD)
      rd_d[CMD_DONE] = done_q;
    else
      rd_hit = 1'b0;
  end

  // apb answer: one wait-free access phase, data registered in setup
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= pwrite ? '0 : rd_d;
        // master status is read only, writes there are refused too
        pslverr_q <= !rd_hit || (pwrite && idx == IDX_MSTAT);
      end
    end
  end

  // holding registers: software stages a value, a counter read refills them
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      top_q <= RST16;
      low_q <= RST16;
    end
    else if (xf_q == XF_BUSY && cnt_ack && !cnt_req_q.wr)
    begin
      top_q <= {8'h00, cnt_rdata[23:16]};
      low_q <= cnt_rdata[15:0];
    end
    else if (wr_acc && idx == IDX_CNT_TOP)
      top_q <= pwdata[15:0] & TOP_RW_MASK;
    else if (wr_acc && idx == IDX_CNT_LOW)
      low_q <= pwdata[15:0];
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_q <= RST16;
      mmask_q <= RST16;
      tc_en_q <= RST16;
      for (int l = 0; l < NLINK; l++)
        len_q[l] <= RST16;
    end
    else if (wr_acc)
    begin
      if (idx == IDX_CNT_SEL)
        sel_q <= pwdata[15:0] & SEL_RW_MASK;
      if (idx == IDX_MMASK)
        mmask_q <= pwdata[15:0];
      if (idx == IDX_TC_EN)
        tc_en_q <= pwdata[15:0];
      if (idx >= IDX_LEN0 && idx < IDX_MSTAT)
        len_q[idx_link] <= pwdata[15:0] & LSTAT_RD_MASK;
    end
  end

  // transfer engine; select codes are trusted, the store sees them as is
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xf_q <= XF_IDLE;
      done_q <= 1'b1;
      cnt_req_q <= '0;
      cnt_req_valid_q <= 1'b0;
    end
    else
    begin
      unique case (xf_q)
        XF_IDLE:
        begin
          if (start)
          begin
            xf_q <= XF_BUSY;
            done_q <= 1'b0;
            cnt_req_valid_q <= 1'b1;
            cnt_req_q.wr <= pwdata[CMD_DIR];
            cnt_req_q.ctype <= sel_q[SEL_TYPE_LSB +: 4];
            cnt_req_q.link <= sel_q[SEL_LINK_LSB +: 4];
            cnt_req_q.data <= {top_q[7:0], low_q};
          end
        end
        XF_BUSY:
        begin
          // request held until the store answers
          if (cnt_ack)
          begin
            xf_q <= XF_IDLE;
            done_q <= 1'b1;
            cnt_req_valid_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // delineation loss level crosses in from the line side
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lcd_s1_q <= '0;
      lcd_s2_q <= '0;
      lcd_s3_q <= '0;
    end
    else
    begin
      lcd_s1_q <= cell_delineation_loss;
      lcd_s2_q <= lcd_s1_q;
      lcd_s3_q <= lcd_s2_q;
    end
  end

  // link status: hardware sets win over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int l = 0; l < NLINK; l++)
        lstat_q[l] <= RST16;
    end
    else
    begin
      for (int l = 0; l < NLINK; l++)
      begin
        if (wr_acc && idx == IDX_LSTAT0 + AW'(l))
        begin
          // writing 0 clears, reserved bits ignored
          if (!pwdata[LS_LCD])
            lstat_q[l][LS_LCD] <= 1'b0;
          if (!pwdata[LS_LCD_END])
            lstat_q[l][LS_LCD_END] <= 1'b0;
        end
        if (lcd_rise[l])
          lstat_q[l][LS_LCD] <= 1'b1;
        if (lcd_fall[l])
          lstat_q[l][LS_LCD_END] <= 1'b1;
      end
    end
  end

  // per-counter overflow flags, cleared by a finished transfer to that counter
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int l = 0; l < NLINK; l++)
        ovf_flag_q[l] <= RST16;
    end
    else
    begin
      if (xf_q == XF_BUSY && cnt_ack)
        ovf_flag_q[cnt_req_q.link][cnt_req_q.ctype] <= 1'b0;
      if (ovf_in.valid)
        ovf_flag_q[ovf_in.link][ovf_in.ctype] <= 1'b1;
    end
  end

  // interrupt pin: low while any masked-in link requests
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irq_n_q <= 1'b1;
    else
      irq_n_q <= !(|(mstat & mmask_q));
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cnt_req = cnt_req_q;
  assign cnt_req_valid = cnt_req_valid_q;
  assign irq_n = irq_n_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_top_read_zero: assert property (pready_q && !pwrite && idx == IDX_CNT_TOP |->
    prdata_q[31:8] == '0 && prdata_q[7:0] == $past(top_q[7:0]))
    else $error("top holding read wrong");
  chk_low_read: assert property (pready_q && !pwrite && idx == IDX_CNT_LOW |->
    prdata_q[15:0] == $past(low_q))
    else $error("low holding read wrong");
  chk_sel_upper_zero: assert property (sel_q[15:9] == '0)
    else $error("select upper bits set");
  chk_xfer_start: assert property (start && xf_q == XF_IDLE |=>
    cnt_req_valid_q && cnt_req_q.data == {$past(top_q[7:0]), $past(low_q)} &&
    cnt_req_q.link == $past(sel_q[3:0]))
    else $error("transfer request not issued");
  chk_hold_no_req: assert property (wr_acc && idx == IDX_CNT_LOW && xf_q == XF_IDLE |=>
    !cnt_req_valid_q)
    else $error("holding write started transfer");
  chk_done_pending: assert property (cnt_req_valid_q |-> !done_q)
    else $error("done high while pending");
  chk_irq_pin: assert property (|(mstat & mmask_q) |=> !irq_n_q)
    else $error("irq pin not low");
  chk_irq_quiet: assert property (mmask_q == '0 |=> irq_n_q)
    else $error("irq pin low with all masked");
  chk_tc_gate: assert property ((mstat & ~tc_en_q & ~len_hi_v) == '0)
    else $error("tc overflow not gated");
  chk_lcd_set: assert property (lcd_rise != '0 |=>
    (lcd_flag_v & $past(lcd_rise)) == $past(lcd_rise))
    else $error("loss flag not set");
  chk_lcd_end_set: assert property (lcd_fall != '0 |=>
    (lcd_end_v & $past(lcd_fall)) == $past(lcd_fall))
    else $error("loss end flag not set");
  chk_ovf_flag: assert property (ovf_in.valid |=> ovf_flag_q[$past(ovf_in.link)] != '0)
    else $error("overflow not recorded");

  cov_read_xfer: cover property (start ##[1:20] (cnt_ack && !cnt_req_q.wr));
  cov_write_xfer: cover property (start ##[1:20] (cnt_ack && cnt_req_q.wr));
  cov_irq: cover property (irq_n_q ##1 !irq_n_q);
  cov_lcd_cycle: cover property (lcd_rise[0] ##[1:50] lcd_fall[0]);

endmodule // cali_top
